/* File: src/tmsc_pkg.sv */
// Purpose: Shared constants and types of the temperature monitor status and setup block.
// Assumes: Register pointers are those of the two-wire bus register map.
// Notes: Time figures are kept in their own units; cycle counts derive from them.
package tmsc_pkg;
    localparam logic [7:0] PTR_STATUS_RD = 8'h02;
    localparam logic [7:0] PTR_SETUP_RD = 8'h03;
    localparam logic [7:0] PTR_PACE_RD = 8'h04;
    localparam logic [7:0] PTR_SETUP_WR = 8'h09;
    localparam logic [7:0] PTR_PACE_WR = 8'h0a;
    localparam logic [7:0] PTR_ONESHOT_WR = 8'h0f;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [7:0] SETUP_WR_MASK = 8'he4;
    localparam logic [3:0] PACE_RESET = 4'h8;
    localparam logic [3:0] PACE_MAX = 4'h9;
    localparam logic [7:0] ALERT_RESP_DATA = 8'h00;
    localparam int SETUP_MASK_BIT = 7;
    localparam int SETUP_SHUT_BIT = 6;
    localparam int SETUP_PIN_BIT = 5;
    localparam int SETUP_RANGE_BIT = 2;
    localparam int CLK_HZ = 10_000_000;
    localparam int PERIOD_MAX_S = 16;
    localparam int PERIOD_MAX_CYCLES = PERIOD_MAX_S * CLK_HZ;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic local_over;
        logic local_under;
        logic remote_over;
        logic remote_under;
        logic remote_open;
        logic remote_therm_over;
        logic local_therm_over;
        logic remote_therm_clear;
        logic local_therm_clear;
    } tmsc_result_s;

    typedef enum logic [1:0] {
        REQ_WRITE = 2'h0,
        REQ_READ = 2'h1,
        REQ_ALERT_RESP = 2'h2
    } tmsc_req_e;

    typedef struct packed {
        tmsc_req_e kind;
        logic [7:0] ptr;
        logic [7:0] data;
    } tmsc_req_s;

    typedef enum logic [2:0] {
        SCH_IDLE = 3'b001,
        SCH_CONV = 3'b010,
        SCH_SHUT = 3'b100
    } tmsc_sched_e;
endpackage

/* File: src/tmsc_status_setup.sv */
// Purpose: Status flags, alert latch, thermal outputs, setup register and conversion pacing.
// Assumes: The serial engine delivers pointer accesses on link_clk; the converter answers
//          each conv_start with one conv_done pulse carrying comparator results.
// Notes: Pins are open drain; a pin is pulled low while its enable is high.
`timescale 1ns/1ns
`default_nettype none

// Function
// [R01] Status bit 7 high while converting.
// [R02] Bits 6 and 5: local over and under.
// [R03] Bits 4 and 3: remote over and under.
// [R04] Bit 2 set on open remote sensor.
// [R05] Bits 1 and 0: remote, local thermal trips.
// [R06] Over sets always; under only in alert mode.
// [R07] Alert mode: five flags sticky; else only open.
// [R08] Any of five flags sets alert latch; latch sets in alert mode only.
// [R09] Status read clears flags whose cause has gone.
// [R10] Alert latch cleared by alert response read only.
// [R11] Thermal trips clear at limit minus hysteresis.
// [R12] Thermal pin low while either trip stands.
// [R13] Second thermal pin follows only over flags.
// [R14] Setup written at 09h, read 03h, resets 00h.
// [R15] Setup bit 7 masks alert pin in alert mode.
// [R16] Setup bit 6 stops after conversion, enters shutdown.
// [R17] One-shot write converts once while shut down.
// [R18] Setup bit 5 selects shared pin function.
// [R19] Setup bit 2 selects extended range format.
// [R20] Host writes zero to reserved setup bits.
// [R21] Pace read 04h, written 0Ah, resets 08h.
// [R22] Pace codes halve period; idle time only.
// [R23] Write to 0Fh starts one cycle, data dropped.
module tmsc_status_setup #(
    parameter int BASE_PERIOD_CYCLES = tmsc_pkg::PERIOD_MAX_CYCLES
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic link_req_valid,
    input wire tmsc_pkg::tmsc_req_s link_req,
    output logic link_req_ready,
    output logic [7:0] link_rdata,
    output logic link_rdata_valid,
    output logic conv_start,
    input wire logic conv_done,
    input wire tmsc_pkg::tmsc_result_s conv_result,
    output logic range_extended,
    output logic alert_pin_o,
    output logic alert_pin_oe,
    output logic therm_pin_o,
    output logic therm_pin_oe
);
    function automatic logic [27:0] period_of(input logic [3:0] code);
        logic [3:0] c;
        c = (code > tmsc_pkg::PACE_MAX) ? tmsc_pkg::PACE_MAX : code;
        period_of = 28'(BASE_PERIOD_CYCLES) >> c;
    endfunction

    // Link side: the request is held stable while a toggle carries it across.
    logic [1:0] link_rst_sync, ack_sync_l;
    logic link_rst_n, req_tgl, ack_seen, link_pending, ack_tgl;
    tmsc_pkg::tmsc_req_s link_hold;
    logic [7:0] rd_data;

    always_ff @(posedge link_clk) begin
        link_rst_sync <= {link_rst_sync[0], reset_n};
    end
    assign link_rst_n = link_rst_sync[1];

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            ack_sync_l <= 2'h0;
        end else begin
            ack_sync_l <= {ack_sync_l[0], ack_tgl};
        end
    end
    assign link_pending = req_tgl != ack_sync_l[1];
    assign link_req_ready = link_rst_n && !link_pending;

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            req_tgl <= 1'b0;
            link_hold <= '0;
        end else if (link_req_valid && link_req_ready) begin
            req_tgl <= ~req_tgl;
            link_hold <= link_req;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            ack_seen <= 1'b0;
            link_rdata <= 8'h00;
            link_rdata_valid <= 1'b0;
        end else begin
            ack_seen <= ack_sync_l[1];
            link_rdata_valid <= 1'b0;
            if (ack_seen != ack_sync_l[1] && link_hold.kind != tmsc_pkg::REQ_WRITE) begin
                link_rdata <= rd_data;
                link_rdata_valid <= 1'b1;
            end
        end
    end

    // Core side: detect each request toggle and perform the access once.
    logic [1:0] req_sync;
    logic req_seen, acc_do;
    logic wr_setup, wr_pace, wr_oneshot, stat_rd, ara_do;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            req_sync <= 2'h0;
            req_seen <= 1'b0;
            ack_tgl <= 1'b0;
        end else begin
            req_sync <= {req_sync[0], req_tgl};
            req_seen <= req_sync[1];
            if (acc_do) begin
                ack_tgl <= ~ack_tgl;
            end
        end
    end
    assign acc_do = req_sync[1] != req_seen;
    assign wr_setup = acc_do && link_hold.kind == tmsc_pkg::REQ_WRITE
        && link_hold.ptr == tmsc_pkg::PTR_SETUP_WR;
    assign wr_pace = acc_do && link_hold.kind == tmsc_pkg::REQ_WRITE
        && link_hold.ptr == tmsc_pkg::PTR_PACE_WR;
    assign wr_oneshot = acc_do && link_hold.kind == tmsc_pkg::REQ_WRITE
        && link_hold.ptr == tmsc_pkg::PTR_ONESHOT_WR;
    assign stat_rd = acc_do && link_hold.kind == tmsc_pkg::REQ_READ
        && link_hold.ptr == tmsc_pkg::PTR_STATUS_RD;
    assign ara_do = acc_do && link_hold.kind == tmsc_pkg::REQ_ALERT_RESP;

    logic [7:0] setup;
    logic [3:0] pace;
    logic alert_mode;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            setup <= tmsc_pkg::SETUP_RESET; // R14
        end else if (wr_setup) begin
            setup <= link_hold.data & tmsc_pkg::SETUP_WR_MASK; // R14 R20
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pace <= tmsc_pkg::PACE_RESET; // R21
        end else if (wr_pace) begin
            pace <= link_hold.data[3:0]; // R21
        end
    end
    assign alert_mode = !setup[tmsc_pkg::SETUP_PIN_BIT]; // R18
    assign range_extended = setup[tmsc_pkg::SETUP_RANGE_BIT]; // R19

    // Conversion scheduler; the period runs from each start, so only idle time varies.
    tmsc_pkg::tmsc_sched_e sched;
    logic [27:0] pace_cnt;
    logic shut;
    assign shut = setup[tmsc_pkg::SETUP_SHUT_BIT];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pace_cnt <= 28'h0000000;
        end else if (conv_start) begin
            // Loading two keeps consecutive starts exactly one period apart.
            pace_cnt <= 28'h0000002; // R22
        end else if (pace_cnt != 28'hfffffff) begin
            pace_cnt <= pace_cnt + 28'h0000001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sched <= tmsc_pkg::SCH_IDLE;
            conv_start <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            case (sched)
                tmsc_pkg::SCH_IDLE: begin
                    if (shut) begin
                        sched <= tmsc_pkg::SCH_SHUT; // R16
                    end else if (pace_cnt >= period_of(pace) || pace_cnt == 28'h0000000) begin
                        sched <= tmsc_pkg::SCH_CONV; // R22
                        conv_start <= 1'b1;
                    end
                end
                tmsc_pkg::SCH_CONV: begin
                    if (conv_done) begin
                        sched <= shut ? tmsc_pkg::SCH_SHUT : tmsc_pkg::SCH_IDLE; // R16
                    end
                end
                tmsc_pkg::SCH_SHUT: begin
                    if (!shut || wr_oneshot) begin
                        sched <= tmsc_pkg::SCH_CONV; // R16 R17 R23
                        conv_start <= 1'b1;
                    end
                end
                default: begin
                    sched <= tmsc_pkg::SCH_IDLE;
                end
            endcase
        end
    end

    // Latest comparator results stand as the causes of the flags.
    tmsc_pkg::tmsc_result_s cond;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cond <= '0;
        end else if (conv_done) begin
            cond <= conv_result;
        end
    end

    logic local_over_flag, local_under_flag, remote_over_flag, remote_under_flag;
    logic open_flag, remote_thermal_trip, local_thermal_trip;
    logic alert_latch;
    logic [4:0] five;
    logic [7:0] status;
    logic done_lo, done_ro;
    assign done_lo = conv_done && conv_result.local_over;
    assign done_ro = conv_done && conv_result.remote_over;

    // A new trip wins over a clear in the same cycle.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            local_over_flag <= 1'b0;
            remote_over_flag <= 1'b0;
        end else if (alert_mode) begin
            local_over_flag <= done_lo
                || (local_over_flag && !(stat_rd && !cond.local_over)); // R02 R06 R07 R09
            remote_over_flag <= done_ro
                || (remote_over_flag && !(stat_rd && !cond.remote_over)); // R03 R06 R07 R09
        end else if (conv_done) begin
            local_over_flag <= conv_result.local_over; // R06 R07
            remote_over_flag <= conv_result.remote_over; // R06 R07
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            local_under_flag <= 1'b0;
            remote_under_flag <= 1'b0;
            open_flag <= 1'b0;
        end else begin
            local_under_flag <= (alert_mode && conv_done && conv_result.local_under)
                || (local_under_flag && !(stat_rd && !cond.local_under)); // R02 R06 R09
            remote_under_flag <= (alert_mode && conv_done && conv_result.remote_under)
                || (remote_under_flag && !(stat_rd && !cond.remote_under)); // R03 R06 R09
            open_flag <= (conv_done && conv_result.remote_open)
                || (open_flag && !(stat_rd && !cond.remote_open)); // R04 R07 R09
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            local_thermal_trip <= 1'b0;
            remote_thermal_trip <= 1'b0;
        end else if (conv_done) begin
            local_thermal_trip <= conv_result.local_therm_over
                || (local_thermal_trip && !conv_result.local_therm_clear); // R05 R11
            remote_thermal_trip <= conv_result.remote_therm_over
                || (remote_thermal_trip && !conv_result.remote_therm_clear); // R05 R11
        end
    end

    assign five = {local_over_flag, local_under_flag, remote_over_flag,
        remote_under_flag, open_flag};
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            alert_latch <= 1'b0;
        end else if (alert_mode && (|five)) begin
            alert_latch <= 1'b1; // R08
        end else if (ara_do && !(|{cond.local_over, cond.local_under, cond.remote_over,
            cond.remote_under, cond.remote_open})) begin
            alert_latch <= 1'b0; // R10
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            alert_pin_oe <= 1'b0;
            therm_pin_oe <= 1'b0;
        end else begin
            alert_pin_oe <= alert_mode ? (alert_latch && !setup[tmsc_pkg::SETUP_MASK_BIT])
                : (local_over_flag || remote_over_flag); // R13 R15 R18
            therm_pin_oe <= local_thermal_trip || remote_thermal_trip; // R12
        end
    end
    assign alert_pin_o = 1'b0;
    assign therm_pin_o = 1'b0;
    assign status = {sched == tmsc_pkg::SCH_CONV, five, remote_thermal_trip,
        local_thermal_trip}; // R01 R02 R03 R04 R05
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
        end else if (acc_do) begin
            if (link_hold.kind == tmsc_pkg::REQ_ALERT_RESP) begin
                rd_data <= tmsc_pkg::ALERT_RESP_DATA;
            end else begin
                case (link_hold.ptr)
                    tmsc_pkg::PTR_STATUS_RD: rd_data <= status;
                    tmsc_pkg::PTR_SETUP_RD: rd_data <= setup; // R14
                    tmsc_pkg::PTR_PACE_RD: rd_data <= {4'h0, pace}; // R21
                    default: rd_data <= 8'h00;
                endcase
            end
        end
    end

    property p_busy;
        @(posedge mclk) disable iff (!reset_n) conv_start |-> status[7] ##0 !$past(status[7]);
    endproperty
    a_busy: assert property (p_busy) else $error("busy bit not raised at start"); // R01
    property p_over_set;
        @(posedge mclk) disable iff (!reset_n) done_lo |=> local_over_flag;
    endproperty
    a_over_set: assert property (p_over_set) else $error("local over flag missed"); // R02
    property p_under_ignored;
        @(posedge mclk) disable iff (!reset_n)
            !alert_mode && !local_under_flag && !wr_setup |=> !local_under_flag;
    endproperty
    a_under_ignored: assert property (p_under_ignored) else $error("under flag set"); // R06
    property p_sticky;
        @(posedge mclk) disable iff (!reset_n)
            alert_mode && !wr_setup && remote_over_flag && !stat_rd |=> remote_over_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky flag lost"); // R07
    property p_read_clear;
        @(posedge mclk) disable iff (!reset_n)
            open_flag && stat_rd && !cond.remote_open && !conv_done |=> !open_flag;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("open flag not cleared"); // R09
    property p_latch_hold;
        @(posedge mclk) disable iff (!reset_n) alert_latch && !ara_do |=> alert_latch;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("alert latch dropped"); // R10
    property p_alert_pin;
        @(posedge mclk) disable iff (!reset_n)
            alert_mode && (|five) && !wr_setup && !setup[7] |=> ##1 alert_pin_oe;
    endproperty
    a_alert_pin: assert property (p_alert_pin) else $error("alert pin not driven"); // R08
    property p_therm;
        @(posedge mclk) disable iff (!reset_n)
            conv_done && conv_result.remote_therm_over |=> ##1 therm_pin_oe;
    endproperty
    a_therm: assert property (p_therm) else $error("thermal pin not driven"); // R12
    property p_shutdown;
        @(posedge mclk) disable iff (!reset_n)
            sched == tmsc_pkg::SCH_CONV && conv_done && shut |=> sched == tmsc_pkg::SCH_SHUT;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not entered"); // R16
    property p_oneshot;
        @(posedge mclk) disable iff (!reset_n)
            sched == tmsc_pkg::SCH_SHUT && wr_oneshot |=> conv_start;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot not started"); // R23
    c_conv: cover property (@(posedge mclk) disable iff (!reset_n) conv_start ##[1:50] conv_done);
    c_alert: cover property (@(posedge mclk) disable iff (!reset_n) alert_latch ##1 !alert_latch);
    c_one: cover property (@(posedge mclk) disable iff (!reset_n)
        sched == tmsc_pkg::SCH_SHUT && wr_oneshot);
endmodule

`default_nettype wire

/* File: testbench/tmsc_conv_model.sv */
// Purpose: Behavioural temperature converter standing behind the status and setup block.
// Assumes: Each conv_start pulse is answered lat mclk cycles later by one conv_done pulse.
// Notes: Outside the done cycle the result lines carry the inverse, so stale use shows up.
`timescale 1ns/1ns
`default_nettype none
module tmsc_conv_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic conv_start,
    input wire logic [7:0] lat,
    input wire tmsc_pkg::tmsc_result_s result,
    output logic conv_done,
    output tmsc_pkg::tmsc_result_s conv_result
);
    logic [7:0] cnt;

    // Inputs of the block change on the falling edge, away from its sampling edge.
    always_ff @(negedge mclk) begin
        conv_done <= 1'b0;
        conv_result <= ~result;
        if (!reset_n) begin
            cnt <= 8'h00;
        end else if (conv_start === 1'b1) begin
            cnt <= lat;
        end else if (cnt == 8'h01) begin
            conv_done <= 1'b1;
            conv_result <= result;
            cnt <= 8'h00;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the status, alert, thermal and setup block.
// Assumes: Base period shortened to 2048 cycles, so rate code 8 gives 8 cycles.
// Notes: Most tests run in shutdown with one-shot conversions to keep flags deterministic.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int BASE = 2048;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic link_req_valid = 1'b0;
    tmsc_pkg::tmsc_req_s link_req = '0;
    logic link_req_ready, link_rdata_valid, conv_start, conv_done, range_extended;
    logic alert_pin_o, alert_pin_oe, therm_pin_o, therm_pin_oe;
    logic [7:0] link_rdata;
    logic [7:0] rd;
    logic [7:0] model_lat = 8'h02;
    tmsc_pkg::tmsc_result_s conv_result;
    tmsc_pkg::tmsc_result_s model_res = 9'h003;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    int n, i;

    always #50 mclk = ~mclk;
    // The link clock is offset so its edges drift against the core clock.
    initial begin
        #1;
        forever #3 link_clk = ~link_clk;
    end

    tmsc_status_setup #(.BASE_PERIOD_CYCLES(BASE)) dut (.mclk, .reset_n, .link_clk,
        .link_req_valid, .link_req, .link_req_ready, .link_rdata, .link_rdata_valid,
        .conv_start, .conv_done, .conv_result, .range_extended, .alert_pin_o,
        .alert_pin_oe, .therm_pin_o, .therm_pin_oe);

    tmsc_conv_model conv (.mclk, .reset_n, .conv_start, .lat(model_lat),
        .result(model_res), .conv_done, .conv_result);

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            close_out();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // The request is held until the edge that samples ready high, then dropped.
    task automatic xfer(input logic [1:0] k, input logic [7:0] p, input logic [7:0] d);
        int w;
        w = 0;
        @(negedge link_clk);
        link_req_valid = 1'b1;
        link_req.kind = tmsc_pkg::tmsc_req_e'(k);
        link_req.ptr = p;
        link_req.data = d;
        @(posedge link_clk);
        while (link_req_ready !== 1'b1 && w < 200) begin
            w++;
            @(posedge link_clk);
        end
        @(negedge link_clk);
        link_req_valid = 1'b0;
        w = 0;
        if (k == 2'h0) begin
            while (link_req_ready !== 1'b1 && w < 200) begin
                w++;
                @(negedge link_clk);
            end
        end else begin
            while (link_rdata_valid !== 1'b1 && w < 200) begin
                w++;
                @(negedge link_clk);
            end
            rd = link_rdata;
        end
        if (w >= 200) begin
            failures++;
        end
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        xfer(2'h0, p, d);
    endtask

    task automatic rdchk(input string name, input logic [1:0] k, input logic [7:0] p,
                         input logic [7:0] e);
        xfer(k, p, 8'h00);
        check(name, e, rd);
    endtask

    task automatic wait_start(input int lim);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (conv_start !== 1'b1 && n < lim);
        if (n >= lim) begin
            failures++;
        end
    endtask

    task automatic convert(input logic [8:0] r);
        int w;
        w = 0;
        model_res = r;
        wr(8'h0f, 8'h5a);
        wait_start(400);
        do begin
            @(negedge mclk);
            w++;
        end while (conv_done !== 1'b1 && w < 400);
        repeat (3) @(negedge mclk);
    endtask

    initial begin
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        rdchk("setup_reset", 2'h1, 8'h03, 8'h00);
        rdchk("pace_reset", 2'h1, 8'h04, 8'h08);
        rdchk("unmapped", 2'h1, 8'h07, 8'h00);
        for (i = 0; i < 10; i++) begin
            wr(8'h0a, i[7:0]);
            rdchk("pace_rd", 2'h1, 8'h04, i[7:0]);
            repeat (3) wait_start(5000);
            check("period", BASE >> i, n);
        end
        wr(8'h0a, 8'h08);
        wr(8'h09, 8'he4);
        rdchk("setup_rsv", 2'h1, 8'h03, 8'he4);
        repeat (6) @(negedge mclk);
        check("range", 1'b1, range_extended);
        wr(8'h09, 8'h40);
        repeat (20) @(negedge mclk);
        check("range", 1'b0, range_extended);
        n = 0;
        repeat (300) begin
            @(negedge mclk);
            if (conv_start === 1'b1) begin
                n++;
            end
        end
        check("shut_starts", 0, n);
        model_lat = 8'd40;
        wr(8'h0f, 8'h00);
        wait_start(400);
        rdchk("busy", 2'h1, 8'h02, 8'h80);
        repeat (60) @(negedge mclk);
        rdchk("idle", 2'h1, 8'h02, 8'h00);
        model_lat = 8'd2;
        convert(9'h1fc);
        check("alert_pin", 1'b1, alert_pin_oe);
        check("therm_pin", 1'b1, therm_pin_oe);
        check("pin_level", 2'b00, {alert_pin_o, therm_pin_o});
        rdchk("status_bad", 2'h1, 8'h02, 8'h7f);
        rdchk("status_held", 2'h1, 8'h02, 8'h7f);
        rdchk("alert_resp", 2'h2, 8'h00, 8'h00);
        repeat (4) @(negedge mclk);
        check("alert_kept", 1'b1, alert_pin_oe);
        convert(9'h000);
        check("therm_hyst", 1'b1, therm_pin_oe);
        convert(9'h003);
        check("therm_off", 1'b0, therm_pin_oe);
        rdchk("status_sticky", 2'h1, 8'h02, 8'h7c);
        rdchk("status_clr", 2'h1, 8'h02, 8'h00);
        check("alert_latched", 1'b1, alert_pin_oe);
        rdchk("alert_resp", 2'h2, 8'h00, 8'h00);
        repeat (4) @(negedge mclk);
        check("alert_clr", 1'b0, alert_pin_oe);
        wr(8'h09, 8'he0);
        convert(9'h083);
        check("t2_under", 1'b0, alert_pin_oe);
        rdchk("t2_status", 2'h1, 8'h02, 8'h00);
        convert(9'h183);
        check("t2_over", 1'b1, alert_pin_oe);
        rdchk("t2_flag", 2'h1, 8'h02, 8'h40);
        convert(9'h003);
        check("t2_off", 1'b0, alert_pin_oe);
        wr(8'h09, 8'hc0);
        convert(9'h013);
        check("masked", 1'b0, alert_pin_oe);
        rdchk("open", 2'h1, 8'h02, 8'h04);
        close_out();
    end
endmodule
`default_nettype wire
